// >>> hw/strobe_sequencer_regs.svh
// Purpose: constants for the radio strobe sequencer
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: offsets are byte addresses of aligned words
`ifndef STROBE_SEQUENCER_REGS_SVH
`define STROBE_SEQUENCER_REGS_SVH
`define SEQ_OFF_STROBE 12'h000
`define SEQ_OFF_CTRL 12'h004
`define SEQ_OFF_STATUS 12'h008
`define SEQ_OFF_XYZ 12'h00C
`define SEQ_CTRL_RUN_BIT 0
`define SEQ_CTRL_CPU_BIT 1
`define SEQ_MEM_DEPTH 24
`define SEQ_LAST_PC 5'h17
`define SEQ_OP_WAIT_REG 8'hBB
`define SEQ_OP_WAIT_CMP 8'hB8
`define SEQ_OP_LABEL 8'hBA
`define SEQ_OP_STOP 8'hDF
`define SEQ_OP_NOP 8'hC0
`define SEQ_OP_TXCAL 8'hC1
`define SEQ_OP_RXON 8'hC2
`define SEQ_OP_TXON 8'hC3
`define SEQ_OP_TXCCA 8'hC4
`define SEQ_OP_RFOFF 8'hC5
`endif

// >>> hw/strobe_sequencer_pkg.sv
// Purpose: types shared by the radio strobe sequencer
// Assumes: nothing beyond SystemVerilog packages
// Notes: strobes travel as one packed struct
`default_nettype none
package strobe_sequencer_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_WAIT = 2'b10,
      ST_ACK = 2'b11
   } seq_state_t;
   typedef struct packed {
      logic tx_cal;
      logic rx_on;
      logic tx_on;
      logic tx_cca;
      logic rf_off;
   } strobe_bus_t;
endpackage
`default_nettype wire

// >>> hw/radio_strobe_sequencer_ops.sv
// Purpose: byte-coded program sequencer issuing radio command strobes
// Assumes: timer and radio inputs arrive from pins, so they are synchronised
// Notes: program loaded byte by byte through the strobe register
//
// Design decisions made here: the address map and register access over APB.
`include "strobe_sequencer_regs.svh"
`default_nettype none
module radio_strobe_sequencer_ops (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mac timer and radio status pins
   input wire logic timer_overflow,
   input wire logic timer_compare_value,
   input wire logic cca_clear,
   input wire logic sfd_seen,
   input wire logic strobe_ack,
   // radio strobes and flags
   output strobe_sequencer_pkg::strobe_bus_t strobes,
   output logic rx_enable_strobe_out,
   output logic wait_done_flag,
   output logic program_stopped_flag
);
   // pin synchronisers: first stage read only by the second
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic ovf_prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
         ovf_prev_reg <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= {timer_overflow, timer_compare_value, cca_clear,
            sfd_seen, strobe_ack};
         sync2_reg <= sync1_reg;
         ovf_prev_reg <= sync2_reg[4];
      end
   end
   wire ovf_s = sync2_reg[4];
   wire cmp_s = sync2_reg[3];
   wire cca_s = sync2_reg[2];
   wire sfd_s = sync2_reg[1];
   wire ack_s = sync2_reg[0];
   // overflow counted once per rising edge of the level
   wire ovf_evt = ovf_s & ~ovf_prev_reg;

   // state
   strobe_sequencer_pkg::seq_state_t state_reg;
   strobe_sequencer_pkg::seq_state_t state_next;
   logic [7:0] imem [0:`SEQ_MEM_DEPTH-1];
   logic [4:0] pc_reg;
   logic [4:0] pc_next;
   logic [4:0] wptr_reg;
   logic [4:0] label_reg;
   logic label_ok_reg;
   logic [7:0] x_reg;
   logic [7:0] y_reg;
   logic [7:0] z_reg;
   logic [5:0] wcnt_reg;
   logic cpu_bit_reg;
   logic run_reg;
   logic wait_done_reg;
   logic stop_reg;
   strobe_sequencer_pkg::strobe_bus_t strobe_reg;

   // apb decode; slave always ready, unmapped reads zero with error
   wire apb_acc = psel & penable;
   wire apb_wr = apb_acc & pwrite;
   wire hit_strobe = paddr == `SEQ_OFF_STROBE;
   wire hit_ctrl = paddr == `SEQ_OFF_CTRL;
   wire hit_status = paddr == `SEQ_OFF_STATUS;
   wire hit_xyz = paddr == `SEQ_OFF_XYZ;
   wire hit_any = hit_strobe | hit_ctrl | hit_status | hit_xyz;
   // program and X/Y/Z writes land only while the program is stopped; control and status writes land at any time
   wire load_wr = apb_wr & hit_strobe & ~run_reg &
      (wptr_reg < `SEQ_LAST_PC + 5'h01);
   wire ctrl_wr = apb_wr & hit_ctrl;
   wire status_wr = apb_wr & hit_status;
   wire xyz_wr = apb_wr & hit_xyz & ~run_reg;
   assign pready = 1'b1;
   assign pslverr = apb_acc & ~hit_any;
   assign prdata = !apb_acc ? 32'h00000000 :
      hit_ctrl ? {30'h00000000, cpu_bit_reg, run_reg} :
      hit_status ? {22'h000000, pc_reg, state_reg, label_ok_reg,
         stop_reg, wait_done_reg} :
      hit_xyz ? {8'h00, z_reg, y_reg, x_reg} :
      hit_strobe ? {27'h0000000, wptr_reg} : 32'h00000000;

   // instruction decode
   wire [7:0] op = imem[pc_reg];
   wire neg = op[3];
   logic cond_raw;
   always_comb begin
      unique case (op[2:0])
         3'h0: cond_raw = cca_s;
         3'h1: cond_raw = sfd_s;
         3'h2: cond_raw = cpu_bit_reg;
         3'h3: cond_raw = pc_reg == `SEQ_LAST_PC;
         3'h4: cond_raw = x_reg == 8'h00;
         3'h5: cond_raw = y_reg == 8'h00;
         3'h6: cond_raw = z_reg == 8'h00;
         3'h7: cond_raw = 1'b0;
      endcase
   end
   wire cond = cond_raw ^ neg;
   wire is_skip = ~op[7];
   wire is_waitw = op[7:5] == 3'h4;
   wire is_rpt = op[7:4] == 4'hA;
   wire is_wait_reg = op == `SEQ_OP_WAIT_REG;
   wire is_wait_cmp = op == `SEQ_OP_WAIT_CMP;
   wire is_label = op == `SEQ_OP_LABEL;
   wire is_stop = op == `SEQ_OP_STOP;
   wire is_strobe = op == `SEQ_OP_TXCAL || op == `SEQ_OP_RXON ||
      op == `SEQ_OP_TXON || op == `SEQ_OP_TXCCA || op == `SEQ_OP_RFOFF;
   wire [4:0] pc_inc = (pc_reg == `SEQ_LAST_PC) ? pc_reg : pc_reg + 5'h01;
   wire [5:0] skip_sum = {1'b0, pc_reg} + {3'h0, op[6:4]} + 6'h01;
   wire [4:0] skip_tgt = (skip_sum > {1'b0, `SEQ_LAST_PC}) ?
      `SEQ_LAST_PC : skip_sum[4:0];
   // overflow wait ends on the last counted overflow
   wire wait_ovf = state_reg == strobe_sequencer_pkg::ST_WAIT &&
      (is_wait_reg || is_waitw);
   // register form ends on X leaving one, immediate form on its counter
   wire ovf_done = wait_ovf && ovf_evt &&
      (is_wait_reg ? x_reg == 8'h01 : wcnt_reg == 6'h01);
   wire x_dec = state_reg == strobe_sequencer_pkg::ST_WAIT && is_wait_reg &&
      ovf_evt;
   wire stop_now = state_reg == strobe_sequencer_pkg::ST_EXEC && is_stop;
   wire strobe_fire = state_reg == strobe_sequencer_pkg::ST_EXEC &&
      is_strobe;
   wire start_wr = ctrl_wr & pwdata[`SEQ_CTRL_RUN_BIT] & ~run_reg;

   // next state and pc; undefined codes fall through as a plain step
   always_comb begin
      state_next = state_reg;
      pc_next = pc_reg;
      unique case (state_reg)
         strobe_sequencer_pkg::ST_IDLE: begin
            if (start_wr) begin
               state_next = strobe_sequencer_pkg::ST_EXEC;
               pc_next = 5'h00;
            end
         end
         strobe_sequencer_pkg::ST_EXEC: begin
            if (is_stop) begin
               state_next = strobe_sequencer_pkg::ST_IDLE;
               pc_next = 5'h00;
            end else if (is_skip) begin
               if (op[6:4] == 3'h0) begin
                  if (cond) pc_next = pc_inc;
               end else begin
                  pc_next = cond ? skip_tgt : pc_inc;
               end
            end else if (is_rpt) begin
               pc_next = (cond && label_ok_reg) ? label_reg : pc_inc;
            end else if (is_wait_reg) begin
               if (x_reg == 8'h00) pc_next = pc_inc;
               else state_next = strobe_sequencer_pkg::ST_WAIT;
            end else if (is_waitw || is_wait_cmp) begin
               state_next = strobe_sequencer_pkg::ST_WAIT;
            end else if (is_strobe) begin
               state_next = strobe_sequencer_pkg::ST_ACK;
            end else begin
               pc_next = pc_inc;
            end
         end
         strobe_sequencer_pkg::ST_WAIT: begin
            if (ovf_done || (is_wait_cmp && cmp_s)) begin
               state_next = strobe_sequencer_pkg::ST_EXEC;
               pc_next = pc_inc;
            end
         end
         strobe_sequencer_pkg::ST_ACK: begin
            if (ack_s) begin
               state_next = strobe_sequencer_pkg::ST_EXEC;
               pc_next = pc_inc;
            end
         end
      endcase
   end

   // sequencer state and program counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= strobe_sequencer_pkg::ST_IDLE;
         pc_reg <= 5'h00;
      end else if (clk_en) begin
         state_reg <= state_next;
         pc_reg <= pc_next;
      end
   end

   // write pointer and instruction memory; stop clears all entries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_reg <= 5'h00;
         for (int i = 0; i < `SEQ_MEM_DEPTH; i++) imem[i] <= 8'h00;
      end else if (clk_en) begin
         if (stop_now) begin
            wptr_reg <= 5'h00;
            for (int i = 0; i < `SEQ_MEM_DEPTH; i++) imem[i] <= 8'h00;
         end else if (load_wr) begin
            imem[wptr_reg] <= pwdata[7:0];
            wptr_reg <= wptr_reg + 5'h01;
         end
      end
   end

   // loop label: one level only, new mark overwrites
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         label_reg <= 5'h00;
         label_ok_reg <= 1'b0;
      end else if (clk_en) begin
         if (stop_now) begin
            label_ok_reg <= 1'b0;
         end else if (state_reg == strobe_sequencer_pkg::ST_EXEC &&
               is_label) begin
            label_reg <= pc_inc;
            label_ok_reg <= 1'b1;
         end
      end
   end

   // overflow counter: loaded on entry to a wait, W of zero means 32
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wcnt_reg <= 6'h00;
      end else if (clk_en) begin
         if (state_reg == strobe_sequencer_pkg::ST_EXEC && is_waitw)
            wcnt_reg <= (op[4:0] == 5'h00) ? 6'h20 : {1'b0, op[4:0]};
         else if (state_reg == strobe_sequencer_pkg::ST_EXEC && is_wait_reg)
            wcnt_reg <= (x_reg[7:6] != 2'h0) ? 6'h3F : x_reg[5:0];
         else if (wait_ovf && ovf_evt && !is_wait_reg)
            wcnt_reg <= wcnt_reg - 6'h01;
      end
   end

   // x/y/z: software loads them while stopped; X counts overflows down
   // register wait ends when X reaches zero, so large X values wait fully
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_reg <= 8'h00;
         y_reg <= 8'h00;
         z_reg <= 8'h00;
      end else if (clk_en) begin
         if (xyz_wr) begin
            x_reg <= pwdata[7:0];
            y_reg <= pwdata[15:8];
            z_reg <= pwdata[23:16];
         end else if (x_dec) begin
            x_reg <= x_reg - 8'h01;
         end
      end
   end
   wire wait_reg_done = x_dec && x_reg == 8'h01;

   // control bits; run clears itself when the program halts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_bit_reg <= 1'b0;
         run_reg <= 1'b0;
      end else if (clk_en) begin
         if (ctrl_wr) cpu_bit_reg <= pwdata[`SEQ_CTRL_CPU_BIT];
         if (stop_now) run_reg <= 1'b0;
         else if (start_wr) run_reg <= 1'b1;
      end
   end

   // sticky flags: write one to clear, a same-cycle event wins
   // a register wait starting at zero is complete at once
   wire wait_reg_zero = state_reg == strobe_sequencer_pkg::ST_EXEC &&
      is_wait_reg && x_reg == 8'h00;
   wire wait_evt = (is_waitw && ovf_done) || wait_reg_done ||
      wait_reg_zero;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_done_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else if (clk_en) begin
         if (wait_evt) wait_done_reg <= 1'b1;
         else if (status_wr && pwdata[0]) wait_done_reg <= 1'b0;
         if (stop_now) stop_reg <= 1'b1;
         else if (status_wr && pwdata[1]) stop_reg <= 1'b0;
      end
   end

   // strobes: one-cycle pulses on entry to the acknowledge wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_reg <= '0;
      end else if (clk_en) begin
         strobe_reg.tx_cal <= strobe_fire && op == `SEQ_OP_TXCAL;
         strobe_reg.rx_on <= strobe_fire && op == `SEQ_OP_RXON;
         strobe_reg.tx_on <= strobe_fire && op == `SEQ_OP_TXON;
         strobe_reg.tx_cca <= strobe_fire && op == `SEQ_OP_TXCCA &&
            cca_s;
         strobe_reg.rf_off <= strobe_fire && op == `SEQ_OP_RFOFF;
      end
   end
   assign strobes = strobe_reg;
   assign rx_enable_strobe_out = strobe_reg.rx_on;
   assign wait_done_flag = wait_done_reg;
   assign program_stopped_flag = stop_reg;

   // assertions
   a_ack_holds_pc: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_reg == strobe_sequencer_pkg::ST_ACK && !ack_s
      |=> pc_reg == $past(pc_reg))
      else $error("pc moved before strobe acknowledge");
   a_stop_clears_label: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && stop_now
      |=> !label_ok_reg && pc_reg == 5'h00 && wptr_reg == 5'h00
      && stop_reg)
      else $error("halt left state behind");
   a_wait_reg_zero: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && state_reg ==
      strobe_sequencer_pkg::ST_EXEC && is_wait_reg && x_reg == 8'h00
      |=> state_reg == strobe_sequencer_pkg::ST_EXEC)
      else $error("wait stalled with zero count");
   a_cmp_wait_hold: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && state_reg ==
      strobe_sequencer_pkg::ST_WAIT && is_wait_cmp && !cmp_s
      |=> pc_reg == $past(pc_reg))
      else $error("compare wait released early");
   a_wait_flag_set: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && wait_evt |=> wait_done_reg)
      else $error("wait completion flag not raised");
   a_cca_gate: assert property (@(posedge pclk) disable iff (!presetn)
      strobe_reg.tx_cca |-> $past(cca_s))
      else $error("tx strobe without clear channel");
   a_rpt_no_label: assert property (@(posedge pclk)
      disable iff (!presetn) clk_en && state_reg ==
      strobe_sequencer_pkg::ST_EXEC && is_rpt && !label_ok_reg
      |=> pc_reg == $past(pc_inc))
      else $error("repeat jumped without label");
   a_skip_hold: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && state_reg == strobe_sequencer_pkg::ST_EXEC && is_skip &&
      op[6:4] == 3'h0 && !cond |=> pc_reg == $past(pc_reg))
      else $error("zero skip did not hold");
   c_strobe_ack: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == strobe_sequencer_pkg::ST_ACK ##1 ack_s);
   c_waitw_done: cover property (@(posedge pclk) disable iff (!presetn)
      is_waitw && ovf_done);
   c_repeat_jump: cover property (@(posedge pclk) disable iff (!presetn)
      state_reg == strobe_sequencer_pkg::ST_EXEC && is_rpt && cond &&
      label_ok_reg);
endmodule
`default_nettype wire

// >>> verif/radio_ack_partner.sv
// Purpose: radio core model that answers each command strobe
// Assumes: strobes are one-cycle pulses, ack is a level the radio drives
// Notes: ack is a one-cycle pulse so a stale level cannot free the next strobe
`default_nettype none
module radio_ack_partner #(
   parameter int ACK_DELAY = 6,
   parameter int ACK_HOLD = 1
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // strobe request and answer
   input wire strobe_sequencer_pkg::strobe_bus_t strobes,
   output logic strobe_ack
);
   int cnt;
   // slow answer: delay, then hold ack, then release it low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         strobe_ack <= 1'b0;
      end else if (cnt == 0) begin
         if (strobes != '0) cnt <= 1;
      end else if (cnt < ACK_DELAY) begin
         cnt <= cnt + 1;
      end else if (cnt < ACK_DELAY + ACK_HOLD) begin
         strobe_ack <= 1'b1;
         cnt <= cnt + 1;
      end else begin
         strobe_ack <= 1'b0;
         cnt <= 0;
      end
   end
endmodule
`default_nettype wire

// >>> verif/test_radio_strobe_sequencer_ops.sv
// Purpose: self-checking bench for the radio strobe sequencer
// Assumes: zero-wait APB, radio ack from the partner model
// Notes: a suppressed strobe gets its ack from the bench directly
`include "strobe_sequencer_regs.svh"
`default_nettype none
module test_radio_strobe_sequencer_ops;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic timer_overflow = 1'b0, timer_compare_value = 1'b0;
   logic cca_clear = 1'b0, ack_model, ack_extra = 1'b0;
   logic rx_enable_strobe_out, wait_done_flag, program_stopped_flag;
   wire logic strobe_ack;
   strobe_sequencer_pkg::strobe_bus_t strobes;
   int bad_count = 0, total_checks = 0;
   int cnt[6];
   assign strobe_ack = ack_model | ack_extra;
   always #5 pclk = ~pclk;
   radio_strobe_sequencer_ops radio_strobe_sequencer_ops_inst (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_overflow(timer_overflow),
      .timer_compare_value(timer_compare_value), .cca_clear(cca_clear),
      .sfd_seen(1'b0), .strobe_ack(strobe_ack), .strobes(strobes),
      .rx_enable_strobe_out(rx_enable_strobe_out),
      .wait_done_flag(wait_done_flag),
      .program_stopped_flag(program_stopped_flag));
   radio_ack_partner radio_ack_partner_inst (
      .pclk(pclk), .presetn(presetn), .strobes(strobes),
      .strobe_ack(ack_model));
   // pulse counters: index 0..4 follow the strobe bits, 5 the rx pin
   always @(posedge pclk) begin
      for (int i = 0; i < 5; i++) if (strobes[i] === 1'b1) cnt[i]++;
      if (rx_enable_strobe_out === 1'b1) cnt[5]++;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // one APB transfer; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         timer_overflow <= 1'b1;
         repeat (4) @(posedge pclk);
         timer_overflow <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
   task automatic wait_stop();
      int n;
      for (n = 0; n < 3000 && program_stopped_flag !== 1'b1; n++)
         @(posedge pclk);
      check({31'h0, program_stopped_flag}, 32'h1, "stop timeout");
      if (program_stopped_flag !== 1'b1) test_done();
   endtask
   // clear sticky flags, load a program, start it
   task automatic run(input logic [7:0] prog[$], input logic cpu);
      apb(1'b1, `SEQ_OFF_STATUS, 32'h3);
      foreach (prog[i]) apb(1'b1, `SEQ_OFF_STROBE, {24'h0, prog[i]});
      foreach (cnt[i]) cnt[i] = 0;
      apb(1'b1, `SEQ_OFF_CTRL, {30'h0, cpu, 1'b1});
   endtask
   task automatic t_reset();
      check({27'h0, strobes}, 32'h0, "strobes idle");
      apb(1'b0, `SEQ_OFF_STATUS, 32'h0);
      check(rd, 32'h0, "status reset");
      apb(1'b0, 12'h010, 32'h0);
      check({31'h0, err}, 32'h1, "unmapped error");
      check(rd, 32'h0, "unmapped data");
   endtask
   // every strobe except tx cca once, plus an undefined opcode and a no-op
   task automatic t_strobes();
      run('{8'hC1, 8'hC2, 8'hC3, 8'hD0, 8'hC0, 8'hC5, 8'hDF}, 1'b0);
      wait_stop();
      check(cnt[4], 1, "tx cal");
      check(cnt[3], 1, "rx on");
      check(cnt[5], 1, "rx pin");
      check(cnt[2], 1, "tx on");
      check(cnt[0], 1, "rf off");
      check(cnt[1], 0, "no cca strobe");
      apb(1'b0, `SEQ_OFF_STROBE, 32'h0);
      check(rd & 32'h1F, 32'h0, "write pointer");
      apb(1'b0, `SEQ_OFF_STATUS, 32'h0);
      check(rd & 32'h3E7, 32'h2, "stop status");
   endtask
   task automatic t_cca();
      run('{8'hC4, 8'hDF}, 1'b0);
      repeat (30) @(posedge pclk);
      check(cnt[1], 0, "busy channel");
      check({31'h0, program_stopped_flag}, 32'h0, "held for ack");
      ack_extra <= 1'b1;
      repeat (4) @(posedge pclk);
      ack_extra <= 1'b0;
      wait_stop();
      cca_clear <= 1'b1;
      run('{8'hC4, 8'hDF}, 1'b0);
      wait_stop();
      check(cnt[1], 1, "clear channel");
   endtask
   // overflow waits: immediate W, W zero as 32, register X, X zero
   task automatic t_waits();
      logic [7:0] op[4] = '{8'h83, 8'h80, 8'hBB, 8'hBB};
      int n[4] = '{3, 32, 2, 0};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `SEQ_OFF_XYZ, n[i]);
         run('{op[i], 8'hDF}, 1'b0);
         if (n[i] > 0) begin
            pulse(n[i] - 1);
            repeat (10) @(posedge pclk);
            check({31'h0, program_stopped_flag}, 32'h0, "early");
            check({31'h0, wait_done_flag}, 32'h0, "early flag");
            pulse(1);
         end
         wait_stop();
         check({31'h0, wait_done_flag}, 32'h1, "wait done");
      end
   endtask
   task automatic t_event();
      run('{8'hB8, 8'hDF}, 1'b0);
      repeat (30) @(posedge pclk);
      check({31'h0, program_stopped_flag}, 32'h0, "below compare");
      timer_compare_value <= 1'b1;
      wait_stop();
      timer_compare_value <= 1'b0;
   endtask
   task automatic t_repeat();
      int k;
      run('{8'hBA, 8'hC2, 8'hA2, 8'hDF}, 1'b1);
      for (k = 0; k < 500 && cnt[3] < 2; k++) @(posedge pclk);
      apb(1'b1, `SEQ_OFF_CTRL, 32'h1);
      wait_stop();
      check(cnt[3], 2, "loop count");
      apb(1'b0, `SEQ_OFF_STATUS, 32'h0);
      check(rd & 32'h4, 32'h0, "loop start cleared");
   endtask
   // skip forms against the cpu bit, the unused code and a dead repeat
   task automatic t_skip();
      logic [7:0] op[5] = '{8'h12, 8'h12, 8'h1F, 8'h17, 8'hA2};
      logic cpu[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
      int exp[5] = '{0, 1, 0, 1, 1};
      for (int i = 0; i < 5; i++) begin
         run('{op[i], 8'hC3, 8'hDF}, cpu[i]);
         wait_stop();
         check(cnt[2], exp[i], "skip");
      end
      run('{8'h02, 8'hDF}, 1'b0);
      repeat (40) @(posedge pclk);
      check({31'h0, program_stopped_flag}, 32'h0, "skip hold");
      apb(1'b1, `SEQ_OFF_CTRL, 32'h3);
      wait_stop();
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_strobes();
      t_cca();
      t_waits();
      t_event();
      t_repeat();
      t_skip();
      test_done();
   end
endmodule
`default_nettype wire
